/* File: core/mcpwm_pkg.sv */
package mcpwm_pkg;
  // ----------------------------------------------------------------
  // widths and counts
  // ----------------------------------------------------------------
  localparam int unsigned MCPWM_PER_W     = 16;           // period / duty width
  localparam int unsigned MCPWM_NUM_CH    = 6;            // implemented channels
  localparam int unsigned MCPWM_SEL_W     = 4;            // channel select width
  localparam int unsigned MCPWM_CH_MAX    = 15;           // highest select value
  localparam int unsigned MCPWM_GRP_SIZE  = 3;            // channels per period group
  localparam int unsigned MCPWM_NUM_GRP   = 2;            // period groups
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] MCPWM_PER_RST   = 16'hFFFF;     // period after reset
  localparam logic [15:0] MCPWM_DUTY_RST  = 16'h0000;     // duty after reset
  localparam logic [15:0] MCPWM_CNT_RST   = 16'h0000;     // counter after reset

  // ----------------------------------------------------------------
  // command carrier
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MCPWM_OP_NONE,                                        // idle
    MCPWM_OP_START,                                       // load duty/period, run
    MCPWM_OP_STOP                                         // halt channel
  } mcpwm_op_t;

  typedef struct packed {
    mcpwm_op_t        op;                                 // command kind
    logic [3:0]       chan;                               // channel select 0..15
    logic [15:0]      duty;                               // duty value
    logic [15:0]      period;                             // period value
  } mcpwm_cmd_t;
endpackage

/* File: core/mcpwm_group.sv */
`timescale 1ns/10ps
// one period group: a shared wrapping counter and three duty comparators
module mcpwm_group
  import mcpwm_pkg::*;
#(
  parameter int unsigned W = MCPWM_PER_W                  // counter width
) (
  // clock and reset
  input  wire logic                 clk_in,               // system clock
  input  wire logic                 resetn_in,            // async reset, low
  // configuration from the command decoder
  input  wire logic [W-1:0]         period_in,            // pending period
  input  wire logic [2:0][W-1:0]    duty_in,              // pending duties
  input  wire logic [2:0]           run_in,               // channel run flags
  // waveform
  output logic [2:0]                pwm_out               // channel outputs
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [W-1:0]       cnt_r, cnt_nxt;                     // shared counter
  logic [W-1:0]       per_r, per_nxt;                     // active period
  logic [2:0][W-1:0]  duty_r, duty_nxt;                   // active duties
  logic [2:0]         pwm_r, pwm_nxt;                     // registered outputs
  logic               wrap;                               // last count of a cycle

  // counter wraps at period-1; a zero period just holds at zero
  always_comb begin
    wrap     = (cnt_r >= per_r - W'(1)) || (per_r == '0);
    cnt_nxt  = wrap ? '0 : cnt_r + W'(1);
    // shadows only copy at the wrap so no pulse is cut short
    per_nxt  = wrap ? period_in : per_r;
    duty_nxt = wrap ? duty_in : duty_r;
  end

  // per-channel compare; stopped channels sit low at once
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_cmp
      always_comb begin
        pwm_nxt[g] = run_in[g] && (cnt_nxt < duty_nxt[g]);
      end
    end
  endgenerate

  // register everything
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_r  <= '0;
      per_r  <= W'(MCPWM_PER_RST);
      duty_r <= '0;
      pwm_r  <= '0;
    end else begin
      cnt_r  <= cnt_nxt;
      per_r  <= per_nxt;
      duty_r <= duty_nxt;
      pwm_r  <= pwm_nxt;
    end
  end

  assign pwm_out = pwm_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_cnt_below_per;
    @(posedge clk_in) disable iff (!resetn_in)
      (per_r != '0) |-> (cnt_r < per_r);
  endproperty
  a_cnt_below_per: assert property (p_cnt_below_per)
    else $error("counter reached period");

  property p_wrap_zero;
    @(posedge clk_in) disable iff (!resetn_in)
      wrap |=> (cnt_r == '0);
  endproperty
  a_wrap_zero: assert property (p_wrap_zero)
    else $error("counter did not wrap to zero");

  property p_per_hold;
    @(posedge clk_in) disable iff (!resetn_in)
      !wrap |=> $stable(per_r);
  endproperty
  a_per_hold: assert property (p_per_hold)
    else $error("period changed mid cycle");

  property p_duty_hold;
    @(posedge clk_in) disable iff (!resetn_in)
      !wrap |=> $stable(duty_r);
  endproperty
  a_duty_hold: assert property (p_duty_hold)
    else $error("duty changed mid cycle");

  property p_out_cmp;
    @(posedge clk_in) disable iff (!resetn_in)
      1'b1 |=> (pwm_r[0] == (run_in[0] && (cnt_r < duty_r[0])))
               || !$stable(run_in[0]);
  endproperty
  a_out_cmp: assert property (p_out_cmp)
    else $error("channel 0 output disagrees with compare");

  property p_stop_low;
    @(posedge clk_in) disable iff (!resetn_in)
      !run_in[1] |=> !pwm_r[1];
  endproperty
  a_stop_low: assert property (p_stop_low)
    else $error("stopped channel still high");

  property p_half_square;
    @(posedge clk_in) disable iff (!resetn_in)
      (per_r == W'(16'h0004) && duty_r[2] == W'(16'h0002) && cnt_r == '0
        && run_in[2] && $past(run_in[2]))
        |-> pwm_r[2] ##1 pwm_r[2] ##1 !pwm_r[2] ##1 !pwm_r[2];
  endproperty
  a_half_square: assert property (p_half_square)
    else $error("half duty not high for first half");

  property p_ten_bit;
    @(posedge clk_in) disable iff (!resetn_in)
      (per_r == W'(16'h0400) && wrap && period_in == W'(16'h0400))
        |=> (cnt_r == '0) ##1 (cnt_r == W'(16'h0001));
  endproperty
  a_ten_bit: assert property (p_ten_bit)
    else $error("1024 period does not step by one");

  c_wrap:   cover property (@(posedge clk_in) disable iff (!resetn_in) wrap ##1 !wrap);
  c_high:   cover property (@(posedge clk_in) disable iff (!resetn_in) $rose(pwm_r[0]));
  c_differ: cover property (@(posedge clk_in) disable iff (!resetn_in) pwm_r[0] && !pwm_r[1]);
endmodule // mcpwm_group

/* File: core/mcpwm_top.sv */
`timescale 1ns/10ps
module mcpwm_top
  import mcpwm_pkg::*;
(
  // clock and reset
  input  wire logic                      clk_in,          // 125 MHz system clock
  input  wire logic                      resetn_in,       // async reset, low
  // command port
  input  wire logic                      cmd_valid_in,    // command strobe
  input  wire mcpwm_cmd_t                cmd_in,          // command fields
  output logic                           cmd_ready_out,   // always accepting
  // status and waveforms
  output logic [MCPWM_NUM_CH-1:0]        run_out,         // channel running flags
  output logic [MCPWM_NUM_CH-1:0]        pwm_out          // channel waveforms
);
  // ----------------------------------------------------------------
  // configuration state
  // ----------------------------------------------------------------
  logic [MCPWM_NUM_GRP-1:0][15:0]        per_r, per_nxt;   // period per group
  logic [MCPWM_NUM_CH-1:0][15:0]         duty_r, duty_nxt; // duty per channel
  logic [MCPWM_NUM_CH-1:0]               run_r, run_nxt;   // run flags
  logic                                  hit;              // select names a real channel

  // decode; selects 6..15 are legal but name no hardware, so are dropped
  always_comb begin
    per_nxt  = per_r;
    duty_nxt = duty_r;
    run_nxt  = run_r;
    hit      = cmd_valid_in && (cmd_in.chan < 4'(MCPWM_NUM_CH));
    if (hit) begin
      case (cmd_in.op)
        MCPWM_OP_START: begin
          // one period per group; last writer wins
          if (cmd_in.chan < 4'(MCPWM_GRP_SIZE)) begin
            per_nxt[0] = cmd_in.period;
          end else begin
            per_nxt[1] = cmd_in.period;
          end
          duty_nxt[cmd_in.chan[2:0]] = cmd_in.duty;
          run_nxt[cmd_in.chan[2:0]]  = 1'b1;
        end
        MCPWM_OP_STOP: begin
          run_nxt[cmd_in.chan[2:0]]  = 1'b0;
        end
        default: begin
          run_nxt = run_r;
        end
      endcase
    end
  end

  // register configuration
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      per_r  <= {MCPWM_NUM_GRP{MCPWM_PER_RST}};
      duty_r <= {MCPWM_NUM_CH{MCPWM_DUTY_RST}};
      run_r  <= '0;
    end else begin
      per_r  <= per_nxt;
      duty_r <= duty_nxt;
      run_r  <= run_nxt;
    end
  end

  // every command is decoded in one cycle, so the port never stalls;
  // a caller may therefore stream commands on back-to-back edges
  assign cmd_ready_out = 1'b1;
  assign run_out       = run_r;

  // ----------------------------------------------------------------
  // period groups: 0..2 and 3..5
  // ----------------------------------------------------------------
  // each group owns one shared counter; its channels differ only in duty and run flag,
  // which is why the period is stored per group and the duty per channel
  genvar g;
  generate
    for (g = 0; g < MCPWM_NUM_GRP; g++) begin : g_grp
      mcpwm_group #(
        .W         (MCPWM_PER_W)
      ) u_grp (
        .clk_in    (clk_in),
        .resetn_in (resetn_in),
        .period_in (per_r[g]),
        .duty_in   (duty_r[g*3 +: 3]),
        .run_in    (run_r[g*3 +: 3]),
        .pwm_out   (pwm_out[g*3 +: 3])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_start_runs;
    @(posedge clk_in) disable iff (!resetn_in)
      (cmd_valid_in && cmd_in.op == MCPWM_OP_START && cmd_in.chan == 4'd4)
        |=> run_r[4] && duty_r[4] == $past(cmd_in.duty) && per_r[1] == $past(cmd_in.period);
  endproperty
  a_start_runs: assert property (p_start_runs)
    else $error("start did not load channel 4");

  property p_stop_halts;
    @(posedge clk_in) disable iff (!resetn_in)
      (cmd_valid_in && cmd_in.op == MCPWM_OP_STOP && cmd_in.chan == 4'd1)
        |=> !run_r[1] ##1 !pwm_out[1];
  endproperty
  a_stop_halts: assert property (p_stop_halts)
    else $error("stop did not halt channel 1");

  property p_high_sel;
    @(posedge clk_in) disable iff (!resetn_in)
      (cmd_valid_in && cmd_in.chan >= 4'd6) |=> $stable(run_r);
  endproperty
  a_high_sel: assert property (p_high_sel)
    else $error("unimplemented channel changed state");

  property p_group0;
    @(posedge clk_in) disable iff (!resetn_in)
      (cmd_valid_in && cmd_in.op == MCPWM_OP_START && cmd_in.chan == 4'd2)
        |=> per_r[0] == $past(cmd_in.period) && $stable(per_r[1]);
  endproperty
  a_group0: assert property (p_group0)
    else $error("group 0 period not shared");

  // ----------------------------------------------------------------
  // checks: stored values, run flags and outputs
  // ----------------------------------------------------------------
  // a start on channel 0 loads the group 0 period and its own duty
  property p_start_ch0;
    @(posedge clk_in) disable iff (!resetn_in)
      (cmd_valid_in && cmd_in.op == MCPWM_OP_START && cmd_in.chan == 4'h0)
        |=> run_r[0] && duty_r[0] == $past(cmd_in.duty) && per_r[0] == $past(cmd_in.period);
  endproperty
  a_start_ch0: assert property (p_start_ch0)
    else $error("start did not load channel 0");

  // a start in group 1 leaves the group 0 period alone
  property p_group1;
    @(posedge clk_in) disable iff (!resetn_in)
      (cmd_valid_in && cmd_in.op == MCPWM_OP_START && cmd_in.chan == 4'h3)
        |=> per_r[1] == $past(cmd_in.period) && $stable(per_r[0]);
  endproperty
  a_group1: assert property (p_group1)
    else $error("group 1 period not shared");

  // duties are per channel: a start on channel 1 spares its neighbours
  property p_duty_own;
    @(posedge clk_in) disable iff (!resetn_in)
      (cmd_valid_in && cmd_in.op == MCPWM_OP_START && cmd_in.chan == 4'h1)
        |=> $stable(duty_r[0]) && $stable(duty_r[2]) && duty_r[1] == $past(cmd_in.duty);
  endproperty
  a_duty_own: assert property (p_duty_own)
    else $error("duty written to wrong channel");

  // a stop only clears the run flag; stored values wait for a later start
  property p_stop_keeps;
    @(posedge clk_in) disable iff (!resetn_in)
      (cmd_valid_in && cmd_in.op == MCPWM_OP_STOP && cmd_in.chan == 4'h1)
        |=> !run_r[1] && $stable(duty_r) && $stable(per_r);
  endproperty
  a_stop_keeps: assert property (p_stop_keeps)
    else $error("stop disturbed stored values");

  // with no strobe nothing changes: running channels carry on by themselves
  property p_idle_hold;
    @(posedge clk_in) disable iff (!resetn_in)
      !cmd_valid_in |=> $stable(run_r) && $stable(per_r) && $stable(duty_r);
  endproperty
  a_idle_hold: assert property (p_idle_hold)
    else $error("state changed with no command");

  // an empty operation is ignored even on an implemented channel
  property p_none_ignored;
    @(posedge clk_in) disable iff (!resetn_in)
      (cmd_valid_in && cmd_in.op == MCPWM_OP_NONE)
        |=> $stable(run_r) && $stable(per_r) && $stable(duty_r);
  endproperty
  a_none_ignored: assert property (p_none_ignored)
    else $error("empty operation changed state");

  // selects above the implemented channels leave stored values alone
  property p_high_sel_cfg;
    @(posedge clk_in) disable iff (!resetn_in)
      (cmd_valid_in && cmd_in.chan >= 4'h6) |=> $stable(per_r) && $stable(duty_r);
  endproperty
  a_high_sel_cfg: assert property (p_high_sel_cfg)
    else $error("unimplemented channel changed values");

  // an output may only be high one cycle after its channel was running
  property p_out_needs_run;
    @(posedge clk_in) disable iff (!resetn_in)
      1'b1 |=> ((pwm_out & ~$past(run_r)) == '0);
  endproperty
  a_out_needs_run: assert property (p_out_needs_run)
    else $error("stopped channel drives its output");

  // a run flag only rises on a start command
  property p_run_rise;
    @(posedge clk_in) disable iff (!resetn_in)
      ((run_r & ~$past(run_r)) != '0)
        |-> $past(cmd_valid_in) && $past(cmd_in.op) == MCPWM_OP_START;
  endproperty
  a_run_rise: assert property (p_run_rise)
    else $error("run flag rose without a start");

  // a start on channel 5 fills its own duty slot in group 1
  property p_start_ch5;
    @(posedge clk_in) disable iff (!resetn_in)
      (cmd_valid_in && cmd_in.op == MCPWM_OP_START && cmd_in.chan == 4'h5)
        |=> run_r[5] && duty_r[5] == $past(cmd_in.duty) && $stable(duty_r[3]);
  endproperty
  a_start_ch5: assert property (p_start_ch5)
    else $error("start did not load channel 5");

  c_start: cover property (@(posedge clk_in) disable iff (!resetn_in) $rose(run_r[0]));
  c_stop:  cover property (@(posedge clk_in) disable iff (!resetn_in) $fell(run_r[3]));
endmodule // mcpwm_top

/* File: sim/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import mcpwm_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and observation
  // ----------------------------------------------------------------
  logic                    clk;        // 125 MHz system clock
  logic                    resetn;     // async reset, low
  logic                    cmd_valid;  // command strobe
  mcpwm_cmd_t              cmd;        // command fields
  logic                    cmd_ready;  // design accept flag
  logic [MCPWM_NUM_CH-1:0] run;        // channel running flags
  logic [MCPWM_NUM_CH-1:0] pwm;        // channel waveforms, taken as driven pins
  int                      bad_count;  // mismatches seen
  int                      cmp_count;  // comparisons made
  int                      cycles;     // cycles since time zero

  mcpwm_top dut (
    .clk_in       (clk),
    .resetn_in    (resetn),
    .cmd_valid_in (cmd_valid),
    .cmd_in       (cmd),
    .cmd_ready_out(cmd_ready),
    .run_out      (run),
    .pwm_out      (pwm)
  );

  // ----------------------------------------------------------------
  // clock and hang guard
  // ----------------------------------------------------------------
  initial clk = 1'b0;
  always #4 clk = ~clk;

  // first wrap after reset takes a full 0xffff period, so the ceiling is generous
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 95000) begin
      bad_count++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  // called at a falling edge; holds the strobe so calls run back to back
  task automatic send(input mcpwm_op_t op, input logic [3:0] ch, input logic [15:0] duty,
                      input logic [15:0] per);
    cmd_valid = 1'b1;
    cmd = '{op: op, chan: ch, duty: duty, period: per};
    @(negedge clk);
  endtask

  task automatic idle;
    cmd_valid = 1'b0;
    cmd = '{op: MCPWM_OP_NONE, chan: 4'h0, duty: 16'h0000, period: 16'h0000};
    @(negedge clk);
  endtask

  // measures one full high and low phase starting from a rising edge
  task automatic wave(input string name, input int ch, input int exp_hi, input int exp_per);
    int n;
    int hi;
    int lo;
    n = 0;
    hi = 0;
    lo = 0;
    while (pwm[ch] !== 1'b0 && n < 70000) begin
      @(negedge clk);
      n++;
    end
    while (pwm[ch] !== 1'b1 && n < 70000) begin
      @(negedge clk);
      n++;
    end
    while (pwm[ch] === 1'b1 && hi < 70000) begin
      @(negedge clk);
      hi++;
    end
    while (pwm[ch] === 1'b0 && lo < 70000) begin
      @(negedge clk);
      lo++;
    end
    check({name, " high"}, 32'(hi), 32'(exp_hi));
    check({name, " period"}, 32'(hi + lo), 32'(exp_per));
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    repeat (8) @(negedge clk);
    check("run in reset", 32'(run), 32'h0000_0000);
    check("pwm in reset", 32'(pwm), 32'h0000_0000);
    resetn = 1'b1;
    @(negedge clk);
    check("ready", 32'(cmd_ready), 32'h0000_0001);
  endtask

  // all six channels started back to back so both groups wrap together
  // every duty is kept below its period
  task automatic t_start;
    send(MCPWM_OP_START, 4'h0, 16'h0002, 16'h0004);
    send(MCPWM_OP_START, 4'h1, 16'h0001, 16'h0004);
    send(MCPWM_OP_START, 4'h2, 16'h0002, 16'h0004);
    send(MCPWM_OP_START, 4'h3, 16'h0200, 16'h0400);
    send(MCPWM_OP_START, 4'h4, 16'h0001, 16'h0400);
    send(MCPWM_OP_START, 4'h5, 16'h03FF, 16'h0400);
    idle();
    check("run after start", 32'(run), 32'h0000_003F);
    wave("ch0", 0, 2, 4);
    wave("ch1", 1, 1, 4);
    wave("ch2", 2, 2, 4);
    wave("ch3", 3, 512, 1024);
    wave("ch4", 4, 1, 1024);
    wave("ch5", 5, 1023, 1024);
  endtask

  // duty changed while running: the next whole pulse carries the new width
  task automatic t_update;
    send(MCPWM_OP_START, 4'h0, 16'h0003, 16'h0004);
    idle();
    wave("ch0 update", 0, 3, 4);
    wave("ch2 kept", 2, 2, 4);
  endtask

  task automatic t_stop;
    int i;
    send(MCPWM_OP_STOP, 4'h1, 16'h0000, 16'h0000);
    idle();
    check("run after stop", 32'(run), 32'h0000_003D);
    for (i = 0; i < 8; i++) begin
      @(negedge clk);
      check("ch1 stopped", 32'(pwm[1]), 32'h0000_0000);
    end
    wave("ch0 still running", 0, 3, 4);
  endtask

  // selects 6..15 are legal but drive nothing; low bits must not alias
  task automatic t_unused_sel;
    int c;
    for (c = 6; c <= MCPWM_CH_MAX; c++) begin
      send(MCPWM_OP_START, 4'(c), 16'h0001, 16'h0008);
      send(MCPWM_OP_STOP, 4'(c), 16'h0000, 16'h0000);
    end
    // an empty operation on the stopped channel must not restart it
    send(MCPWM_OP_NONE, 4'h1, 16'h0001, 16'h0004);
    idle();
    check("run after unused", 32'(run), 32'h0000_003D);
    wave("ch0 unaliased", 0, 3, 4);
    wave("ch3 unaliased", 3, 512, 1024);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    bad_count = 0;
    cmp_count = 0;
    cycles = 0;
    resetn = 1'b0;
    cmd_valid = 1'b0;
    cmd = '{op: MCPWM_OP_NONE, chan: 4'h0, duty: 16'h0000, period: 16'h0000};
    t_reset();
    t_start();
    t_update();
    t_stop();
    t_unused_sel();
    test_done();
  end
endmodule // tb_top
